// ---- ulmsc_core.sv ----
// line status, modem control and modem status registers of a serial channel
`timescale 1ns/1ps
`include "ulmsc_cfg.svh"
module ulmsc_core (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  input wire logic divisor_access_in,
  input wire logic [3:0] irq_enable_in,
  input wire logic rx_load_in,
  input wire logic rx_parity_err_in,
  input wire logic rx_framing_err_in,
  input wire logic rx_break_in,
  input wire logic tx_to_shifter_in,
  input wire logic tx_shifter_empty_in,
  input wire logic tx_serial_in,
  input wire logic serial_in,
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic ri_n_in,
  input wire logic dcd_n_in,
  output logic serial_out,
  output logic rx_serial_out,
  output logic dtr_n_out,
  output logic rts_n_out,
  output logic irq_request_out,
  output logic [3:0] irq_source_out,
  output logic rx_buffer_read_out,
  output logic tx_holding_write_out,
  output logic irq_id_read_out
);
  ulmsc_sync_if pins_if ();
  ulmsc_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .port_if(pins_if.sync)
  );
  // pin gathering, synchronised by two flip-flops each
  assign pins_if.raw = {serial_in, dcd_n_in, ri_n_in, dsr_n_in, cts_n_in,
                        data_in, addr_in, cs_n_in, wr_n_in, rd_n_in};

  wire logic rd_s = ~pins_if.synced[`ULMSC_S_RD];
  wire logic wr_s = ~pins_if.synced[`ULMSC_S_WR];
  wire logic cs_s = ~pins_if.synced[`ULMSC_S_CS];
  wire logic [2:0] addr_s = pins_if.synced[`ULMSC_S_ADDR +: 3];
  wire logic [7:0] data_s = pins_if.synced[`ULMSC_S_DATA +: 8];
  wire logic [3:0] modem_n_s = {pins_if.synced[`ULMSC_S_DCD],
                                pins_if.synced[`ULMSC_S_RI],
                                pins_if.synced[`ULMSC_S_DSR],
                                pins_if.synced[`ULMSC_S_CTS]};
  wire logic sin_s = pins_if.synced[`ULMSC_S_SIN];

  // bus access sequencer
  ulmsc_pkg::ulmsc_bus_state_t state_ff;
  ulmsc_pkg::ulmsc_bus_state_t nxt_state;
  logic [2:0] addr_q_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  wire logic rd_act = rd_s & cs_s;
  wire logic wr_act = wr_s & cs_s;
  wire logic st_idle = (state_ff == ulmsc_pkg::ULMSC_IDLE);
  wire logic st_read = (state_ff == ulmsc_pkg::ULMSC_READ);
  wire logic rd_start = st_idle & rd_act;
  wire logic wr_start = st_idle & ~rd_act & wr_act;
  wire logic rd_end = st_read & ~rd_act;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ulmsc_pkg::ULMSC_IDLE: begin
        if (rd_act) begin
          nxt_state = ulmsc_pkg::ULMSC_READ;
        end else if (wr_act) begin
          nxt_state = ulmsc_pkg::ULMSC_WRITE;
        end
      end
      ulmsc_pkg::ULMSC_READ: begin
        if (!rd_act) begin
          nxt_state = ulmsc_pkg::ULMSC_IDLE;
        end
      end
      ulmsc_pkg::ULMSC_WRITE: begin
        if (!wr_act) begin
          nxt_state = ulmsc_pkg::ULMSC_IDLE;
        end
      end
      default: begin
        nxt_state = ulmsc_pkg::ULMSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_ff <= ulmsc_pkg::ULMSC_IDLE;
      addr_q_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      if (rd_start) begin
        addr_q_ff <= addr_s;
      end
    end
  end

  // address decode
  wire logic lsr_in_read = st_read & (addr_q_ff == `ULMSC_OFF_LSTAT);
  wire logic msr_in_read = st_read & (addr_q_ff == `ULMSC_OFF_MSTAT);
  wire logic lsr_rd_go = rd_start & (addr_s == `ULMSC_OFF_LSTAT);
  wire logic msr_rd_go = rd_start & (addr_s == `ULMSC_OFF_MSTAT);
  wire logic rbr_rd = rd_start & (addr_s == `ULMSC_OFF_BUFFER) &
                      ~divisor_access_in;
  wire logic iir_rd = rd_start & (addr_s == `ULMSC_OFF_IRQ_ID);
  wire logic thr_wr = wr_start & (addr_s == `ULMSC_OFF_BUFFER) &
                      ~divisor_access_in;
  wire logic mcr_wr = wr_start & (addr_s == `ULMSC_OFF_MCTL);
  assign rx_buffer_read_out = rbr_rd;
  assign tx_holding_write_out = thr_wr;
  assign irq_id_read_out = iir_rd;

  // modem control register
  logic [4:0] mcr_ff;
  wire logic loop_on = mcr_ff[`ULMSC_MCR_LOOP];
  wire logic [7:0] mcr_rd = {3'h0, mcr_ff} & `ULMSC_MCR_MASK;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mcr_ff <= `ULMSC_MCR_RST;
    end else if (mcr_wr) begin
      mcr_ff <= data_s[4:0] & `ULMSC_MCR_WMASK;
    end
  end

  // modem input levels, true when the line is asserted
  wire logic [3:0] pin_lvl = ~modem_n_s;
  wire logic [3:0] loop_lvl = {mcr_ff[`ULMSC_MCR_INTEN], 1'b0,
                               mcr_ff[`ULMSC_MCR_DTR],
                               mcr_ff[`ULMSC_MCR_RTS]};
  wire logic [3:0] modem_lvl = loop_on ? loop_lvl : pin_lvl;
  logic [3:0] lvl_q_ff;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      lvl_q_ff <= `ULMSC_LVL_RST;
    end else begin
      lvl_q_ff <= modem_lvl;
    end
  end

  wire logic [3:0] lvl_chg = modem_lvl ^ lvl_q_ff;
  wire logic ring_fall = modem_lvl[2] & ~lvl_q_ff[2];

  // receive data ready
  logic ready_ff;
  wire logic overrun_ev = rx_load_in & ready_ff;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ready_ff <= 1'b0;
    end else if (rx_load_in) begin
      ready_ff <= 1'b1;
    end else if (rbr_rd) begin
      ready_ff <= 1'b0;
    end
  end

  // sticky flags: 3..0 line errors, 7..4 modem deltas
  wire logic [7:0] flag_ev = {lvl_chg[3], ring_fall, lvl_chg[1], lvl_chg[0],
                              rx_break_in, rx_framing_err_in,
                              rx_parity_err_in, overrun_ev};
  wire logic [7:0] grp_read = {{4{msr_in_read | msr_rd_go}},
                               {4{lsr_in_read | lsr_rd_go}}};
  wire logic [7:0] grp_end = grp_read & {8{rd_end}};
  logic [7:0] flag_ff;
  logic [7:0] pend_ff;
  logic [7:0] nxt_flag;
  logic [7:0] nxt_pend;

  genvar fi;
  generate
    for (fi = 0; fi < 8; fi = fi + 1) begin : g_flag
      // events during a read wait for its trailing edge
      assign nxt_pend[fi] = grp_read[fi] & ~grp_end[fi] &
                            (pend_ff[fi] | flag_ev[fi]);
      assign nxt_flag[fi] = grp_end[fi] ? (pend_ff[fi] | flag_ev[fi]) :
                            grp_read[fi] ? flag_ff[fi] :
                            (flag_ff[fi] | flag_ev[fi]);
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      flag_ff <= `ULMSC_FLAGS_RST;
      pend_ff <= `ULMSC_FLAGS_RST;
    end else begin
      flag_ff <= nxt_flag;
      pend_ff <= nxt_pend;
    end
  end

  // transmitter empty flags
  logic tx_holding_empty_ff;
  logic tx_holding_empty_irq_ff;
  wire logic tx_fully_empty = tx_holding_empty_ff & tx_shifter_empty_in;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tx_holding_empty_ff <= 1'b1;
    end else if (tx_to_shifter_in) begin
      tx_holding_empty_ff <= 1'b1;
    end else if (thr_wr) begin
      tx_holding_empty_ff <= 1'b0;
    end
  end

  // interrupt sources in priority order
  wire logic ls_int = |flag_ff[3:0] & irq_enable_in[`ULMSC_IER_LS];
  wire logic rda_int = ready_ff & irq_enable_in[`ULMSC_IER_RDA];
  wire logic tx_holding_empty_int = tx_holding_empty_ff & tx_holding_empty_irq_ff &
                        irq_enable_in[`ULMSC_IER_TX_HOLDING_EMPTY];
  wire logic ms_int = |flag_ff[7:4] & irq_enable_in[`ULMSC_IER_MS];
  wire logic tx_holding_empty_top = tx_holding_empty_int & ~ls_int & ~rda_int;
  wire logic any_int = ls_int | rda_int | tx_holding_empty_int | ms_int;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tx_holding_empty_irq_ff <= 1'b1;
    end else if (tx_to_shifter_in) begin
      tx_holding_empty_irq_ff <= 1'b1;
    end else if (thr_wr || (iir_rd && tx_holding_empty_top)) begin
      tx_holding_empty_irq_ff <= 1'b0;
    end
  end

  assign irq_source_out = {ms_int, tx_holding_empty_int, rda_int, ls_int};

  // register views
  wire logic [7:0] lsr_rd = {1'b0, tx_fully_empty, tx_holding_empty_ff, flag_ff[3:0],
                             ready_ff};
  wire logic [7:0] msr_rd = {modem_lvl, flag_ff[7:4]};

  always_comb begin
    case (addr_s)
      `ULMSC_OFF_MCTL: nxt_rd_data = mcr_rd;
      `ULMSC_OFF_LSTAT: nxt_rd_data = lsr_rd;
      `ULMSC_OFF_MSTAT: nxt_rd_data = msr_rd;
      default: nxt_rd_data = 8'h00;
    endcase
  end

  // registered pin outputs
  logic serial_out_ff;
  logic rxs_ff;
  logic dtr_n_ff;
  logic rts_n_ff;
  logic irq_ff;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rd_data_ff <= 8'h00;
      serial_out_ff <= 1'b1;
      rxs_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
      rts_n_ff <= 1'b1;
      irq_ff <= 1'b0;
    end else begin
      if (rd_start) begin
        rd_data_ff <= nxt_rd_data;
      end
      serial_out_ff <= loop_on | tx_serial_in;
      rxs_ff <= loop_on ? tx_serial_in : sin_s;
      dtr_n_ff <= loop_on | ~mcr_ff[`ULMSC_MCR_DTR];
      rts_n_ff <= loop_on | ~mcr_ff[`ULMSC_MCR_RTS];
      irq_ff <= any_int & mcr_ff[`ULMSC_MCR_INTEN];
    end
  end

  assign data_out = rd_data_ff;
  assign data_oe_n_out = ~st_read;
  assign serial_out = serial_out_ff;
  assign rx_serial_out = rxs_ff;
  assign dtr_n_out = dtr_n_ff;
  assign rts_n_out = rts_n_ff;
  assign irq_request_out = irq_ff;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence lsr_read_done;
    rd_end && (addr_q_ff == `ULMSC_OFF_LSTAT) && (flag_ev[3:0] == 4'h0) &&
      (pend_ff[3:0] == 4'h0);
  endsequence
  sequence ring_edge_outside_read;
    !grp_read[4] && ring_fall;
  endsequence
  sequence quiet_write;
    thr_wr && !tx_to_shifter_in;
  endsequence
  ready_set_a: assert property (rx_load_in |=> ready_ff)
    else $error("data ready not set after load");
  overrun_set_a: assert property (
    (rx_load_in && ready_ff && !grp_read[0]) |=> flag_ff[0])
    else $error("overrun not flagged");
  error_clear_a: assert property (
    lsr_read_done |=> (flag_ff[3:0] == 4'h0))
    else $error("error flags not cleared by status read");
  read_hold_a: assert property (
    (lsr_in_read && !rd_end && rx_parity_err_in && !flag_ff[1])
      |=> !flag_ff[1] && pend_ff[1])
    else $error("flag set during status read");
  tx_holding_empty_clear_a: assert property (
    quiet_write |=> !tx_holding_empty_ff ##0 !tx_fully_empty)
    else $error("holding empty not cleared by write");
  tx_holding_empty_keep_a: assert property (
    (tx_holding_empty_ff && rd_start && !thr_wr) |=> tx_holding_empty_ff)
    else $error("holding empty lost on read");
  dtr_pin_a: assert property (
    (!loop_on && mcr_ff[`ULMSC_MCR_DTR]) |=> !dtr_n_out)
    else $error("terminal ready pin not asserted");
  rts_pin_a: assert property (
    (!loop_on && !mcr_ff[`ULMSC_MCR_RTS]) |=> rts_n_out)
    else $error("request to send pin not released");
  loop_pins_a: assert property (
    loop_on |=> serial_out && dtr_n_out && rts_n_out)
    else $error("loopback outputs not inactive");
  irq_gate_a: assert property (
    !mcr_ff[`ULMSC_MCR_INTEN] |=> !irq_request_out)
    else $error("interrupt not gated");
  ring_fall_a: assert property (
    ring_edge_outside_read |=> flag_ff[6])
    else $error("ring falling edge missed");
  ring_rise_a: assert property (
    (!msr_in_read && !flag_ff[6] && !modem_lvl[2] && lvl_q_ff[2])
      |=> !flag_ff[6])
    else $error("ring rising edge flagged");
  ls_irq_a: assert property (
    (|flag_ff[3:0] && irq_enable_in[`ULMSC_IER_LS] &&
      mcr_ff[`ULMSC_MCR_INTEN]) |=> irq_request_out)
    else $error("line status interrupt missing");
endmodule : ulmsc_core

// ---- ulmsc_cfg.svh ----
// register offsets, bit positions, reset values and sync layout
`ifndef ULMSC_CFG_SVH
`define ULMSC_CFG_SVH
`define ULMSC_OFF_BUFFER 3'h0
`define ULMSC_OFF_IRQ_ID 3'h2
`define ULMSC_OFF_MCTL 3'h4
`define ULMSC_OFF_LSTAT 3'h5
`define ULMSC_OFF_MSTAT 3'h6
`define ULMSC_MCR_DTR 0
`define ULMSC_MCR_RTS 1
`define ULMSC_MCR_INTEN 3
`define ULMSC_MCR_LOOP 4
`define ULMSC_MCR_MASK 8'h1B
`define ULMSC_MCR_WMASK 5'h1B
`define ULMSC_MCR_RST 5'h00
`define ULMSC_IER_RDA 0
`define ULMSC_IER_TX_HOLDING_EMPTY 1
`define ULMSC_IER_LS 2
`define ULMSC_IER_MS 3
`define ULMSC_FLAGS_RST 8'h00
`define ULMSC_LVL_RST 4'h0
`define ULMSC_SYNC_W 19
`define ULMSC_SYNC_RST 19'h7FFFF
`define ULMSC_S_RD 0
`define ULMSC_S_WR 1
`define ULMSC_S_CS 2
`define ULMSC_S_ADDR 3
`define ULMSC_S_DATA 6
`define ULMSC_S_CTS 14
`define ULMSC_S_DSR 15
`define ULMSC_S_RI 16
`define ULMSC_S_DCD 17
`define ULMSC_S_SIN 18
`endif

// ---- ulmsc_pkg.sv ----
// types shared by the status and modem control block
package ulmsc_pkg;
  typedef enum logic [2:0] {
    ULMSC_IDLE = 3'b001,
    ULMSC_READ = 3'b010,
    ULMSC_WRITE = 3'b100
  } ulmsc_bus_state_t;
endpackage : ulmsc_pkg

// ---- ulmsc_sync_if.sv ----
// carrier between the pin synchroniser and the core
`timescale 1ns/1ps
`include "ulmsc_cfg.svh"
interface ulmsc_sync_if;
  logic [`ULMSC_SYNC_W-1:0] raw;
  logic [`ULMSC_SYNC_W-1:0] synced;
  modport core (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : ulmsc_sync_if

// ---- ulmsc_sync.sv ----
// two flip-flop synchroniser for every pin input
`timescale 1ns/1ps
`include "ulmsc_cfg.svh"
module ulmsc_sync (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  ulmsc_sync_if.sync port_if
);
  logic [`ULMSC_SYNC_W-1:0] meta_ff;
  logic [`ULMSC_SYNC_W-1:0] sync_ff;
  localparam logic [`ULMSC_SYNC_W-1:0] sync_rst = `ULMSC_SYNC_RST;

  genvar gi;
  generate
    for (gi = 0; gi < `ULMSC_SYNC_W; gi = gi + 1) begin : g_bit
      always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
          meta_ff[gi] <= sync_rst[gi];
          sync_ff[gi] <= sync_rst[gi];
        end else begin
          meta_ff[gi] <= port_if.raw[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  assign port_if.synced = sync_ff;
endmodule : ulmsc_sync

// ---- ulmsc_modem_model.sv ----
// modem or data set model on the handshake and serial pins
`timescale 1ns/1ps
module ulmsc_modem_model (
  input wire logic clk_sys_in,
  input wire logic dtr_n_in,
  input wire logic rts_n_in,
  output logic cts_n_out,
  output logic dsr_n_out,
  output logic ri_n_out,
  output logic dcd_n_out,
  output logic serial_in_out
);
  logic [3:0] lines_ff = 4'hF;
  logic follow_ff = 1'b0;
  int lag_ff = 1;
  logic [1:0] hist_q[$];
  logic [1:0] late = 2'h3;

  initial begin
    cts_n_out = 1'b1;
    dsr_n_out = 1'b1;
    ri_n_out = 1'b1;
    dcd_n_out = 1'b1;
    serial_in_out = 1'b1;
  end

  // lines are {carrier, ring, set ready, clear to send}, all active low
  task automatic set_lines(input logic [3:0] nl);
    follow_ff <= 1'b0;
    lines_ff <= nl;
  endtask : set_lines

  task automatic set_serial(input logic b);
    serial_in_out <= b;
  endtask : set_serial

  // answer the handshake outputs after lag cycles, prompt or slow
  task automatic follow(input int lag);
    lag_ff = lag;
    follow_ff <= 1'b1;
  endtask : follow

  always @(posedge clk_sys_in) begin
    hist_q.push_back({dtr_n_in, rts_n_in});
    if (hist_q.size() > lag_ff) begin
      late = hist_q.pop_front();
    end
    cts_n_out <= follow_ff ? late[0] : lines_ff[0];
    dsr_n_out <= follow_ff ? late[1] : lines_ff[1];
    ri_n_out <= lines_ff[2];
    dcd_n_out <= lines_ff[3];
  end
endmodule : ulmsc_modem_model

// ---- tb_top.sv ----
// self-checking bench for the status and modem control block
`timescale 1ns/1ps
`include "ulmsc_cfg.svh"
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
  end \
end
module tb_top;
  typedef struct {logic [7:0] v; logic [7:0] m;} ulmsc_exp_t;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] irq_en = 4'h0;
  logic rx_load = 1'b0;
  logic [2:0] rx_err = 3'h0;
  logic tx_move = 1'b0;
  logic tx_sh_empty = 1'b1;
  logic tx_ser = 1'b1;
  logic [7:0] data_out;
  logic data_oe_n_out;
  logic serial_out, rx_ser_out, dtr_n, rts_n, irq_req;
  logic [3:0] irq_src;
  logic rbr_rd, thr_wr, iid_rd, cts_n, dsr_n, ri_n, dcd_n, ser_in;
  int n_fail = 0;
  int num_checks = 0;
  int n_rbr = 0;
  int n_thr = 0;
  int n_iid = 0;
  logic oe_prev = 1'b1;
  ulmsc_exp_t exp_q[$];
  ulmsc_exp_t cur;
  logic [31:0] seed = 32'h8874B571;
  logic [7:0] v;
  logic [3:0] nl, old, d;

  ulmsc_core u_ulmsc_core (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr),
    .data_in(wdata), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
    .divisor_access_in(1'b0), .irq_enable_in(irq_en),
    .rx_load_in(rx_load), .rx_parity_err_in(rx_err[0]),
    .rx_framing_err_in(rx_err[1]), .rx_break_in(rx_err[2]),
    .tx_to_shifter_in(tx_move), .tx_shifter_empty_in(tx_sh_empty),
    .tx_serial_in(tx_ser), .serial_in(ser_in), .cts_n_in(cts_n),
    .dsr_n_in(dsr_n), .ri_n_in(ri_n), .dcd_n_in(dcd_n),
    .serial_out(serial_out), .rx_serial_out(rx_ser_out),
    .dtr_n_out(dtr_n), .rts_n_out(rts_n), .irq_request_out(irq_req),
    .irq_source_out(irq_src), .rx_buffer_read_out(rbr_rd),
    .tx_holding_write_out(thr_wr), .irq_id_read_out(iid_rd));

  ulmsc_modem_model u_ulmsc_modem_model (.clk_sys_in(clk_sys_in),
    .dtr_n_in(dtr_n), .rts_n_in(rts_n), .cts_n_out(cts_n),
    .dsr_n_out(dsr_n), .ri_n_out(ri_n), .dcd_n_out(dcd_n),
    .serial_in_out(ser_in));

  always #4 clk_sys_in = ~clk_sys_in;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc

  task automatic wait_oe(input logic lvl);
    int k;
    k = 0;
    while (data_oe_n_out !== lvl && k < 16) begin
      @(posedge clk_sys_in);
      k++;
    end
    if (k == 16) begin
      n_fail++;
      $display("mismatch at %0t: bus answer missing", $time);
    end
  endtask : wait_oe

  task automatic rd(input logic [2:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    exp_q.push_back('{e, m});
    @(posedge clk_sys_in);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    @(posedge clk_sys_in);
    wait_oe(1'b0);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wait_oe(1'b1);
    cyc(2);
  endtask : rd

  task automatic wr(input logic [2:0] a, input logic [7:0] dv);
    @(posedge clk_sys_in);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    addr <= a;
    wdata <= dv;
    cyc(4);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    cyc(4);
  endtask : wr

  task automatic rx_char(input logic [2:0] err);
    @(posedge clk_sys_in);
    rx_load <= 1'b1;
    rx_err <= err;
    @(posedge clk_sys_in);
    rx_load <= 1'b0;
    rx_err <= 3'h0;
  endtask : rx_char

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // read results are checked and strobe pulses counted as they appear
  always @(posedge clk_sys_in) begin
    if (oe_prev === 1'b1 && data_oe_n_out === 1'b0) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("mismatch at %0t: read not expected", $time);
      end else begin
        cur = exp_q.pop_front();
        `CHK(data_out & cur.m, cur.v & cur.m)
      end
    end
    oe_prev = data_oe_n_out;
    if (rbr_rd === 1'b1) n_rbr++;
    if (thr_wr === 1'b1) n_thr++;
    if (iid_rd === 1'b1) n_iid++;
  end

  initial begin
    cyc(20000);
    n_fail++;
    wrap_up();
  end

  initial begin
    cyc(3);
    rst_n_in <= 1'b1;
    rd(`ULMSC_OFF_LSTAT, 8'h60, 8'hFF);
    rd(`ULMSC_OFF_MCTL, 8'h00, 8'hFF);
    rd(`ULMSC_OFF_MSTAT, 8'h00, 8'hFF);
    `CHK({dtr_n, rts_n, irq_req}, 3'b110)
    wr(`ULMSC_OFF_LSTAT, 8'hFF);
    rd(`ULMSC_OFF_LSTAT, 8'h60, 8'hFF);
    rd(3'h7, 8'h00, 8'hFF);
    rd(3'h3, 8'h00, 8'hFF);
    // random control values, loop mode on and off
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 8'hFF : seed[7:0];
      tx_ser <= seed[8];
      u_ulmsc_modem_model.set_serial(seed[9]);
      wr(`ULMSC_OFF_MCTL, v);
      rd(`ULMSC_OFF_MCTL, v & 8'h1B, 8'hFF);
      `CHK(dtr_n, v[4] | ~v[0])
      `CHK(rts_n, v[4] | ~v[1])
      `CHK(serial_out, v[4] | seed[8])
      `CHK(rx_ser_out, v[4] ? seed[8] : seed[9])
      rd(`ULMSC_OFF_MSTAT, v[4] ? {v[3], 1'b0, v[0], v[1], 4'h0} : 8'h00,
         8'hF0);
    end
    wr(`ULMSC_OFF_MCTL, 8'h08);
    rd(`ULMSC_OFF_MSTAT, 8'h00, 8'h00);
    // receive flags and the line status interrupt
    irq_en <= 4'h4;
    rx_char(3'b001);
    rx_char(3'b110);
    cyc(3);
    `CHK({irq_req, irq_src[0]}, 2'b11)
    wr(`ULMSC_OFF_MCTL, 8'h00);
    `CHK(irq_req, 1'b0)
    wr(`ULMSC_OFF_MCTL, 8'h08);
    `CHK(irq_req, 1'b1)
    rd(`ULMSC_OFF_LSTAT, 8'h7F, 8'hFF);
    cyc(2);
    `CHK(irq_req, 1'b0)
    rd(`ULMSC_OFF_LSTAT, 8'h61, 8'hFF);
    rd(`ULMSC_OFF_BUFFER, 8'h00, 8'h00);
    rd(`ULMSC_OFF_LSTAT, 8'h60, 8'hFF);
    fork
      rd(`ULMSC_OFF_LSTAT, 8'h60, 8'hFF);
      begin
        cyc(4);
        rx_char(3'b001);
      end
    join
    rd(`ULMSC_OFF_LSTAT, 8'h65, 8'hFF);
    rd(`ULMSC_OFF_BUFFER, 8'h00, 8'h00);
    `CHK(n_rbr, 2)
    // transmit empty flags and the holding empty interrupt
    irq_en <= 4'h2;
    cyc(3);
    `CHK(irq_req, 1'b1)
    `CHK(irq_src, 4'h4)
    wr(`ULMSC_OFF_BUFFER, 8'hA5);
    `CHK({irq_req, n_thr[1:0]}, 3'b001)
    rd(`ULMSC_OFF_LSTAT, 8'h00, 8'hFF);
    tx_move <= 1'b1;
    tx_sh_empty <= 1'b0;
    cyc(1);
    tx_move <= 1'b0;
    rd(`ULMSC_OFF_LSTAT, 8'h20, 8'hFF);
    rd(`ULMSC_OFF_LSTAT, 8'h20, 8'hFF);
    `CHK(irq_req, 1'b1)
    rd(`ULMSC_OFF_IRQ_ID, 8'h00, 8'h00);
    cyc(2);
    `CHK({irq_req, n_iid[1:0]}, 3'b001)
    tx_sh_empty <= 1'b1;
    rd(`ULMSC_OFF_LSTAT, 8'h60, 8'hFF);
    // random modem line changes
    irq_en <= 4'h8;
    old = 4'hF;
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      nl = seed[3:0];
      u_ulmsc_modem_model.set_lines(nl);
      cyc(6);
      d = {old[3] ^ nl[3], old[2] & ~nl[2], old[1] ^ nl[1], old[0] ^ nl[0]};
      `CHK(irq_req, |d)
      `CHK(irq_src[3], |d)
      rd(`ULMSC_OFF_MSTAT, {~nl, d}, 8'hFF);
      rd(`ULMSC_OFF_MSTAT, {~nl, 4'h0}, 8'hFF);
      old = nl;
    end
    // data set answering the handshake promptly, then slowly
    u_ulmsc_modem_model.set_lines(4'hF);
    cyc(6);
    rd(`ULMSC_OFF_MSTAT, 8'h00, 8'h00);
    u_ulmsc_modem_model.follow(1);
    wr(`ULMSC_OFF_MCTL, 8'h0B);
    cyc(4);
    rd(`ULMSC_OFF_MSTAT, 8'h33, 8'hFF);
    u_ulmsc_modem_model.follow(9);
    wr(`ULMSC_OFF_MCTL, 8'h08);
    cyc(12);
    rd(`ULMSC_OFF_MSTAT, 8'h03, 8'hFF);
    `CHK(exp_q.size(), 0)
    wrap_up();
  end
endmodule : tb_top
